// >>> rtc_pkg.sv
// Purpose: Shared constants for the modulo counter block
// Assumes: 32-bit AHB-Lite register slave, 25 MHz system clock
// Notes: Register offsets are byte addresses
package rtc_pkg;
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_MOD = 8'h04;
    localparam logic [7:0] OFS_CNT = 8'h08;
    localparam int CTRL_IE_BIT = 6;
    localparam int CTRL_IF_BIT = 7;
    localparam int CTRL_OE_BIT = 4;
    localparam int CTRL_PS_LSB = 8;
    localparam int CTRL_CS_LSB = 14;
    localparam logic [2:0] PS_OFF = 3'h0;
    localparam logic [1:0] CS_RESET = 2'h0;
    localparam logic [15:0] MOD_RESET = 16'h0000;
    localparam logic [15:0] CNT_RESET = 16'h0000;
    // Clock source codes
    localparam logic [1:0] CS_EXT = 2'h0;
    localparam logic [1:0] CS_LPO = 2'h1;
    localparam logic [1:0] CS_IREF = 2'h2;
    localparam logic [1:0] CS_BUS = 2'h3;
endpackage : rtc_pkg

// >>> rtc_prescaler.sv
// Purpose: Divides the selected source edge stream into counter ticks
// Assumes: Source is a one-cycle enable pulse in the system clock domain
// Notes: Code 0 stops the prescaler and clears its count
`timescale 1ns/100ps
module rtc_prescaler (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Control
    input wire logic src_en_i,
    input wire logic [2:0] ps_i,
    input wire logic high_range_i,
    // Tick
    output logic tick_o
);
    import rtc_pkg::*;

    typedef struct packed {
        logic [9:0] cnt;
        logic tick;
        logic half;
    } pre_s;

    pre_s q, d;

    function automatic logic [9:0] div_last(input logic [2:0] ps, input logic hi);
        logic [10:0] r;
        r = 11'h001;
        case ({hi, ps})
            4'h1: r = 11'h001;
            4'h2: r = 11'h002;
            4'h3: r = 11'h004;
            4'h4: r = 11'h008;
            4'h5: r = 11'h010;
            4'h6: r = 11'h020;
            4'h7: r = 11'h040;
            4'h9: r = 11'h080;
            4'hA: r = 11'h100;
            4'hB: r = 11'h200;
            4'hC: r = 11'h400;
            4'hD: r = 11'h800 - 11'h001;
            4'hE: r = 11'h064;
            4'hF: r = 11'h3E8;
            default: r = 11'h001;
        endcase
        // 2048 would not fit; its ticks come from a divide-by-1024 stage doubled below
        return r[9:0] - 10'h001;
    endfunction : div_last

    logic [9:0] last;
    logic dbl;

    always_comb begin
        last = div_last(ps_i, high_range_i);
        dbl = high_range_i && (ps_i == 3'h5);
        if (dbl) begin
            last = 10'h3FF;
        end
        d = q;
        d.tick = 1'b0;
        // A stale half from another setting would shorten the first 2048 period
        if (!dbl) begin
            d.half = 1'b0;
        end
        if (ps_i == PS_OFF) begin
            d.cnt = 10'h000;
        end else if (src_en_i) begin
            // At or past the end, so lowering the setting never waits for a wrap
            if (q.cnt >= last) begin
                d.cnt = 10'h000;
                d.tick = 1'b1;
                if (dbl) begin
                    d.half = ~q.half;
                end
            end else begin
                d.cnt = q.cnt + 10'h001;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // Divide by 2048 passes every second wrap of the 1024 stage
    assign tick_o = dbl ? (q.tick && !q.half) : q.tick;
endmodule : rtc_prescaler

// >>> rtc_modulo_counter.sv
// Purpose: Modulo counter with selectable source, prescaler, flag and square output
// Assumes: External, low-power and reference clocks arrive as synchronous levels
// Notes: Source edges are detected on the system clock; slow sources only
//        The counter keeps running across configuration writes
//        A source must stay at or below half the system clock rate for its edges to be seen
`timescale 1ns/100ps
module rtc_modulo_counter (
    // Clock and reset
    input wire logic CLK_SYS_I,
    input wire logic RESET_N_I,
    // AHB-Lite slave
    input wire logic HSEL_I,
    input wire logic [31:0] HADDR_I,
    input wire logic [1:0] HTRANS_I,
    input wire logic HWRITE_I,
    input wire logic [2:0] HSIZE_I,
    input wire logic [31:0] HWDATA_I,
    input wire logic HREADY_I,
    output logic [31:0] HRDATA_O,
    output logic HREADYOUT_O,
    output logic HRESP_O,
    // Clock sources
    input wire logic EXTERNAL_CLOCK_I,
    input wire logic LOW_POWER_OSCILLATOR_CLOCK_I,
    input wire logic INTERNAL_REFERENCE_CLOCK_I,
    // Outputs
    output logic COUNTER_SQUARE_OUTPUT_O,
    output logic IRQ_O
);
    import rtc_pkg::*;

    typedef struct packed {
        logic wr_pend;
        logic [7:0] wr_addr;
        logic [1:0] cs;
        logic [2:0] ps;
        logic ie;
        logic oe;
        logic flag;
        logic [15:0] modv;
        logic [15:0] cnt;
        logic sq;
        logic irq;
        logic [31:0] rdata;
        logic [2:0] src_prev;
    } state_s;

    state_s q, d;
    // Reset release stages; they reset from the pin, the rest from their output
    logic [1:0] rst_sync_q;
    logic rst_n;
    logic tick;
    logic src_en;
    logic [2:0] src_now;

    assign rst_n = rst_sync_q[1];
    assign src_now = {INTERNAL_REFERENCE_CLOCK_I, LOW_POWER_OSCILLATOR_CLOCK_I,
                      EXTERNAL_CLOCK_I};

    // Control word as software reads it
    function automatic logic [31:0] ctrl_word(input state_s s);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[CTRL_OE_BIT] = s.oe;
        w[CTRL_IE_BIT] = s.ie;
        w[CTRL_IF_BIT] = s.flag;
        w[CTRL_PS_LSB +: 3] = s.ps;
        w[CTRL_CS_LSB +: 2] = s.cs;
        return w;
    endfunction : ctrl_word

    // Sees the configuration after a write landing in the same cycle, so a read
    // right behind a write returns the new contents
    function automatic logic [31:0] reg_read(input state_s s, input logic [15:0] cnt_now,
        input logic [7:0] a);
        logic [31:0] w;
        w = 32'h0000_0000;
        case (a)
            OFS_CTRL: w = ctrl_word(s);
            OFS_MOD: w = {16'h0000, s.modv};
            OFS_CNT: w = {16'h0000, cnt_now};
            default: w = 32'h0000_0000;
        endcase
        return w;
    endfunction : reg_read

    // Rising edge of the selected source; bus clock counts every cycle
    always_comb begin
        case (q.cs)
            CS_EXT: src_en = src_now[0] && !q.src_prev[0];
            CS_LPO: src_en = src_now[1] && !q.src_prev[1];
            CS_IREF: src_en = src_now[2] && !q.src_prev[2];
            CS_BUS: src_en = 1'b1;
            default: src_en = 1'b0;
        endcase
    end

    // Source bit 0 picks the high divide range for the low-power and bus sources
    rtc_prescaler u_pre (
        .clk_i(CLK_SYS_I),
        .rst_n_i(rst_n),
        .src_en_i(src_en),
        .ps_i(q.ps),
        .high_range_i(q.cs[0]),
        .tick_o(tick)
    );

    // Bus decode
    logic addr_phase;
    logic clr_flag;

    always_comb begin
        d = q;
        // History of all three pins, so switching source raises no stale edge
        d.src_prev = src_now;
        clr_flag = 1'b0;
        addr_phase = HSEL_I && HREADY_I && HTRANS_I[1];
        // Data phase of a write lands one cycle after its address phase
        if (q.wr_pend) begin
            case (q.wr_addr)
                OFS_CTRL: begin
                    d.oe = HWDATA_I[CTRL_OE_BIT];
                    d.ie = HWDATA_I[CTRL_IE_BIT];
                    d.ps = HWDATA_I[CTRL_PS_LSB +: 3];
                    d.cs = HWDATA_I[CTRL_CS_LSB +: 2];
                    // Write one to clear
                    clr_flag = HWDATA_I[CTRL_IF_BIT];
                end
                OFS_MOD: d.modv = HWDATA_I[15:0];
                default: ;
            endcase
        end
        // Size is ignored: every register is one whole word
        d.wr_pend = addr_phase && HWRITE_I;
        d.wr_addr = HADDR_I[7:0];
        // Clear goes first so an overflow in the same cycle wins
        if (clr_flag) begin
            d.flag = 1'b0;
        end
        if (tick) begin
            if (q.cnt == q.modv) begin
                d.cnt = CNT_RESET;
                d.flag = 1'b1;
                if (q.oe) begin
                    d.sq = ~q.sq;
                end
            end else begin
                d.cnt = q.cnt + 16'h0001;
            end
        end
        // Request follows the next flag and enable, so it drops with either
        d.irq = d.flag && d.ie;
        if (addr_phase && !HWRITE_I) begin
            d.rdata = reg_read(d, q.cnt, HADDR_I[7:0]);
        end
    end

    // Two-stage release; only the second stage is used
    always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end

    // Everything else resets from the released copy
    always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
        if (!rst_n) begin
            q.wr_pend <= 1'b0;
            q.wr_addr <= 8'h00;
            q.cs <= CS_RESET;
            q.ps <= PS_OFF;
            q.ie <= 1'b0;
            q.oe <= 1'b0;
            q.flag <= 1'b0;
            q.modv <= MOD_RESET;
            q.cnt <= CNT_RESET;
            q.sq <= 1'b0;
            q.irq <= 1'b0;
            q.rdata <= 32'h0000_0000;
            q.src_prev <= 3'h0;
        end else begin
            q.wr_pend <= d.wr_pend;
            q.wr_addr <= d.wr_addr;
            q.cs <= d.cs;
            q.ps <= d.ps;
            q.ie <= d.ie;
            q.oe <= d.oe;
            q.flag <= d.flag;
            q.modv <= d.modv;
            q.cnt <= d.cnt;
            q.sq <= d.sq;
            q.irq <= d.irq;
            q.rdata <= d.rdata;
            q.src_prev <= d.src_prev;
        end
    end

    // Zero wait states and always OKAY
    always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
        if (!rst_n) begin
            HREADYOUT_O <= 1'b1;
            HRESP_O <= 1'b0;
        end else begin
            HREADYOUT_O <= 1'b1;
            HRESP_O <= 1'b0;
        end
    end

    assign HRDATA_O = q.rdata;
    assign COUNTER_SQUARE_OUTPUT_O = q.sq;
    assign IRQ_O = q.irq;
endmodule : rtc_modulo_counter

// >>> rtc_modulo_counter_sva.sv
// Purpose: Port checks for the modulo counter
// Assumes: Enable bits are shadowed from observed bus writes
// Notes: Raw reset disables; the block holds all outputs but HREADYOUT_O low meanwhile
`timescale 1ns/100ps
module rtc_modulo_counter_sva (
    // Clock, reset and bus
    input wire logic CLK_SYS_I,
    input wire logic RESET_N_I,
    input wire logic HSEL_I,
    input wire logic [31:0] HADDR_I,
    input wire logic [1:0] HTRANS_I,
    input wire logic HWRITE_I,
    input wire logic [31:0] HWDATA_I,
    input wire logic HREADY_I,
    input wire logic [31:0] HRDATA_O,
    input wire logic HREADYOUT_O,
    // Counter outputs
    input wire logic COUNTER_SQUARE_OUTPUT_O,
    input wire logic IRQ_O
);
    import rtc_pkg::*;
    logic rd_q, ctl_q, ie_q, oe_q;
    wire ap = HSEL_I && HREADY_I && HTRANS_I[1];
    always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            {rd_q, ctl_q, ie_q, oe_q} <= 4'h0;
        end else begin
            rd_q <= ap && !HWRITE_I;
            ctl_q <= ap && HWRITE_I && HADDR_I[7:0] == OFS_CTRL;
            if (ctl_q) begin
                {ie_q, oe_q} <= {HWDATA_I[CTRL_IE_BIT], HWDATA_I[CTRL_OE_BIT]};
            end
        end
    end
    default clocking cb @(posedge CLK_SYS_I); endclocking
    default disable iff (!RESET_N_I);
    // Control write whose data phase carries the flag bit
    sequence s_clr;
        ap && HWRITE_I && HADDR_I[7:0] == OFS_CTRL ##1 HWDATA_I[CTRL_IF_BIT];
    endsequence
    a_ready_high: assert property (HREADYOUT_O) else $error("wait state seen");
    a_rdata_holds: assert property (!rd_q |-> $stable(HRDATA_O))
        else $error("read data moved");
    a_sq_needs_oe: assert property (!oe_q && !$past(oe_q) |-> $stable(COUNTER_SQUARE_OUTPUT_O))
        else $error("square toggled while disabled");
    a_irq_needs_ie: assert property (!ie_q && !$past(ie_q) |-> !IRQ_O)
        else $error("request without enable");
    a_irq_sticky: assert property (IRQ_O && ie_q && !ctl_q && !$past(ctl_q) |=> IRQ_O)
        else $error("request dropped without clear");
    a_clear_drops: assert property (s_clr |-> ##[1:2] !IRQ_O)
        else $error("flag clear ignored");
    a_sq_with_flag: assert property ($changed(COUNTER_SQUARE_OUTPUT_O) && oe_q && ie_q |-> ##[0:1] IRQ_O)
        else $error("toggle without overflow flag");
endmodule : rtc_modulo_counter_sva
bind rtc_modulo_counter rtc_modulo_counter_sva u_sva (.CLK_SYS_I, .RESET_N_I, .HSEL_I,
    .HADDR_I, .HTRANS_I, .HWRITE_I, .HWDATA_I, .HREADY_I, .HRDATA_O, .HREADYOUT_O,
    .COUNTER_SQUARE_OUTPUT_O, .IRQ_O);

// >>> rtc_modulo_counter_test.sv
// Purpose: Self-checking bench for the modulo counter
// Assumes: Zero-wait slave; source levels pulsed by the bench
// Notes: Settle cycles after each burst absorb tick latency
`timescale 1ns/100ps
module rtc_modulo_counter_test;
    import rtc_pkg::*;
    logic clk = 0, rst_n = 0, hsel = 0, hwrite = 0, sq, irq, hrdy, hresp;
    logic [1:0] htrans = 2'h0;
    logic [2:0] src = 3'h0;
    logic [31:0] haddr = '0, hwdata = '0, hrdata, b, rd;
    int n_errors = 0;
    int n_tests = 0;
    int dv[14] = '{1, 2, 4, 8, 16, 32, 64, 128, 256, 512, 1024, 2048, 100, 1000};
    rtc_modulo_counter dut (.CLK_SYS_I(clk), .RESET_N_I(rst_n), .HSEL_I(hsel),
        .HADDR_I(haddr), .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(3'h2),
        .HWDATA_I(hwdata), .HREADY_I(hrdy), .HRDATA_O(hrdata), .HREADYOUT_O(hrdy),
        .HRESP_O(hresp), .EXTERNAL_CLOCK_I(src[0]), .LOW_POWER_OSCILLATOR_CLOCK_I(src[1]),
        .INTERNAL_REFERENCE_CLOCK_I(src[2]), .COUNTER_SQUARE_OUTPUT_O(sq), .IRQ_O(irq));
    initial begin
        forever #20 clk = ~clk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        do @(posedge clk); while (hrdy !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hrdy !== 1'b1);
        rd = hrdata;
    endtask : bus
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, '0);
        chk(rd, e);
        chk({31'h0, hresp}, 32'h0);
    endtask : rdc
    task automatic pins(input logic [1:0] e);
        chk({30'h0, sq, irq}, {30'h0, e});
    endtask : pins
    // Slow pulses: the block only detects edges on the system clock
    task automatic edges(input int n, input int s);
        repeat (n) begin
            src[s] <= 1'b1;
            repeat (2) @(posedge clk);
            src[s] <= 1'b0;
            repeat (2) @(posedge clk);
        end
        repeat (4) @(posedge clk);
    endtask : edges
    task automatic delta(input int n, input int s, input logic [31:0] e);
        bus(1'b0, OFS_CNT, '0);
        b = rd;
        edges(n, s);
        rdc(OFS_CNT, b + e);
    endtask : delta
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : wrap_up
    initial begin
        repeat (40000) @(posedge clk);
        n_errors++;
        wrap_up();
    end
    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        rdc(OFS_CTRL, 32'h0);
        rdc(OFS_CNT, {16'h0, CNT_RESET});
        rdc(8'h0C, 32'h0);
        bus(1'b1, OFS_MOD, 32'hFFFF);
        rdc(OFS_MOD, 32'hFFFF);
        bus(1'b1, OFS_MOD, 32'h3);
        bus(1'b1, OFS_CNT, 32'h1234);
        rdc(OFS_CNT, 32'h0);
        $display("test 1 done");
        bus(1'b1, OFS_CTRL, 32'h0150);
        edges(3, 0);
        rdc(OFS_CNT, 32'h3);
        pins(2'h0);
        edges(1, 0);
        rdc(OFS_CNT, 32'h0);
        pins(2'h3);
        rdc(OFS_CTRL, 32'h01D0);
        bus(1'b1, OFS_CTRL, 32'h01D0);
        rdc(OFS_CTRL, 32'h0150);
        pins(2'h2);
        bus(1'b1, OFS_CTRL, 32'h0100);
        edges(4, 0);
        rdc(OFS_CTRL, 32'h0180);
        pins(2'h2);
        $display("test 2 done");
        bus(1'b1, OFS_MOD, 32'hFFFF);
        bus(1'b1, OFS_CTRL, 32'h0080);
        delta(3, 0, 32'h0);
        for (int i = 0; i < 14; i++) begin
            bus(1'b1, OFS_CTRL, {16'h0, i < 7 ? CS_EXT : CS_LPO, 14'h0});
            bus(1'b1, OFS_CTRL, {16'h0, i < 7 ? CS_EXT : CS_LPO, 3'h0, 3'(i % 7 + 1), 8'h0});
            delta(dv[i] - 1, i / 7, 32'h0);
            delta(1, i / 7, 32'h1);
        end
        bus(1'b1, OFS_CTRL, {16'h0, CS_IREF, 3'h0, 3'h1, 8'h0});
        delta(2, 2, 32'h2);
        delta(2, 0, 32'h0);
        bus(1'b1, OFS_CTRL, {16'h0, CS_BUS, 3'h0, 3'h1, 8'h0});
        bus(1'b0, OFS_CNT, '0);
        b = rd;
        repeat (256) @(posedge clk);
        bus(1'b0, OFS_CNT, '0);
        chk({31'h0, rd - b inside {32'h2, 32'h3}}, 32'h1);
        $display("test 3 done");
        wrap_up();
    end
endmodule : rtc_modulo_counter_test
